/* File: hw/ulc_defines.svh */
// Register offsets, field positions, reset values and timing counts of the line control block
`ifndef ULC_DEFINES_SVH
`define ULC_DEFINES_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ULC_OFF_DATA 32'h5002_0000
`define ULC_OFF_DIVH 32'h5002_0004
`define ULC_OFF_LCTL 32'h5002_000C
`define ULC_OFF_MCTL 32'h5002_0010
`define ULC_OFF_STAT 32'h5002_007C

// ****************************************************************
// Field positions
// ****************************************************************
`define ULC_DLAB_BIT 7
`define ULC_BRK_BIT 6
`define ULC_EPS_BIT 4
`define ULC_PAR_BIT 3
`define ULC_STOP_BIT 2
`define ULC_LB_BIT 4

// ****************************************************************
// Reset values and timing counts (half bit periods)
// ****************************************************************
`define ULC_LCTL_RST 8'h00
`define ULC_DIV_RST 8'h00
`define ULC_HALF_BIT 3'h2
`define ULC_HALF_STOP15 3'h3
`define ULC_HALF_STOP2 3'h4

`endif

/* File: hw/ulc_pkg.sv */
// Types of the line control block
package ulc_pkg;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulc_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulc_rx_t;

    typedef struct packed {
        logic [7:0] lctl;
        logic loop_en;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        ulc_tx_t tx_st;
        logic [7:0] tx_sh;
        logic [2:0] tx_idx;
        logic [2:0] tx_half;
        logic [15:0] tx_cnt;
        logic ser;
        logic txd;
        ulc_rx_t rx_st;
        logic [7:0] rx_sh;
        logic [2:0] rx_idx;
        logic [2:0] rx_half;
        logic [15:0] rx_cnt;
        logic rx_pbad;
        logic [7:0] rx_data;
        logic rx_rdy;
        logic fe;
        logic pe;
        logic [31:0] rdata;
    } ulc_state_t;

endpackage : ulc_pkg

/* File: hw/ulc_line_ctrl.sv */
// Line control of the serial port with a plain transmitter and receiver
// ****************************************************************
// Contract
// - Divisor select redirects low/high locations to divisor
// - Break bit forces serial output to zero
// - Pin low while break set, outside loopback
// - Parity select one even, zero odd
// - Parity bits writable only while not busy
// - Parity enable switches generation and checking
// - Stop select: one, one-and-half or two
// - Receiver checks only the first stop bit
// - Length field 00/01/10 gives 5/6/7 bits
// - Loopback holds pin high, loops output back
// ****************************************************************
//
// Local design decision: the plain strobed port.
`include "ulc_defines.svh"

module ulc_line_ctrl (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic RXD_I,
    output logic [31:0] RDATA_O,
    output logic TXD_O
);
    import ulc_pkg::*;

    ulc_state_t q;
    ulc_state_t d;
    logic [15:0] div;
    logic busy;
    logic tx_tick;
    logic rx_tick;
    logic [2:0] last_idx;
    logic [2:0] stop_halves;
    logic tx_bit;
    logic ser;
    logic rx_line;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // A divisor of zero or one runs at the clock rate rather than stalling
    function automatic logic tick_f(input logic [15:0] cnt, input logic [15:0] dv);
        tick_f = (dv <= 16'h0001) ? 1'b1 : (cnt == dv - 16'h0001);
    endfunction : tick_f

    function automatic logic par_f(input logic [7:0] data, input logic [1:0] len,
                                   input logic even);
        logic [7:0] m;
        m = data & ~(8'hE0 << len);
        par_f = even ? ^m : ~^m;
    endfunction : par_f

    assign div = {q.divisor_high, q.dll};
    assign busy = (q.tx_st != TX_IDLE) || (q.rx_st != RX_IDLE);
    assign tx_tick = tick_f(q.tx_cnt, div);
    assign rx_tick = tick_f(q.rx_cnt, div);
    assign last_idx = {1'b0, q.lctl[1:0]} + 3'h4;
    assign stop_halves = !q.lctl[`ULC_STOP_BIT] ? `ULC_HALF_BIT :
                         (q.lctl[1:0] == 2'h0) ? `ULC_HALF_STOP15 : `ULC_HALF_STOP2;
    assign tx_bit = (q.tx_st == TX_START) ? 1'b0 :
                    (q.tx_st == TX_DATA) ? q.tx_sh[q.tx_idx] :
                    (q.tx_st == TX_PAR) ? par_f(q.tx_sh, q.lctl[1:0], q.lctl[`ULC_EPS_BIT]) :
                    1'b1;
    assign ser = q.lctl[`ULC_BRK_BIT] ? 1'b0 : tx_bit;
    assign rx_line = q.loop_en ? q.ser : RXD_I;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.rdata = 32'h0000_0000;
        d.ser = ser;
        d.txd = q.loop_en ? 1'b1 : ser;

        // Register reads; clears come before the events below so a set wins
        if (RD_I) begin
            case (ADDR_I)
                `ULC_OFF_DATA: begin
                    if (q.lctl[`ULC_DLAB_BIT]) begin
                        d.rdata = {24'h00_0000, q.dll};
                    end else begin
                        d.rdata = {24'h00_0000, q.rx_data};
                        d.rx_rdy = 1'b0;
                    end
                end
                `ULC_OFF_DIVH: begin
                    if (q.lctl[`ULC_DLAB_BIT]) begin
                        d.rdata = {24'h00_0000, q.divisor_high};
                    end
                end
                `ULC_OFF_LCTL: d.rdata = {24'h00_0000, q.lctl};
                `ULC_OFF_MCTL: d.rdata = {27'h000_0000, q.loop_en, 4'h0};
                `ULC_OFF_STAT: begin
                    d.rdata = {28'h000_0000, q.pe, q.fe, q.rx_rdy, busy};
                    d.fe = 1'b0;
                    d.pe = 1'b0;
                end
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (WR_I) begin
            case (ADDR_I)
                `ULC_OFF_DATA: begin
                    if (q.lctl[`ULC_DLAB_BIT]) begin
                        d.dll = WDATA_I[7:0];
                    end else if (q.tx_st == TX_IDLE) begin
                        // No holding register: a write while sending is dropped
                        d.tx_sh = WDATA_I[7:0];
                        d.tx_st = TX_START;
                        d.tx_half = `ULC_HALF_BIT;
                        d.tx_cnt = 16'h0000;
                    end
                end
                `ULC_OFF_DIVH: begin
                    if (q.lctl[`ULC_DLAB_BIT]) begin
                        d.divisor_high = WDATA_I[7:0];
                    end
                end
                `ULC_OFF_LCTL: begin
                    d.lctl[7:6] = WDATA_I[7:6];
                    d.lctl[2:0] = WDATA_I[2:0];
                    if (!busy) begin
                        d.lctl[4:3] = WDATA_I[4:3];
                    end
                end
                `ULC_OFF_MCTL: d.loop_en = WDATA_I[`ULC_LB_BIT];
                default: ;
            endcase
        end

        // ****************************************************************
        // Transmitter
        // ****************************************************************
        if (q.tx_st != TX_IDLE) begin
            d.tx_cnt = tx_tick ? 16'h0000 : q.tx_cnt + 16'h0001;
            if (tx_tick) begin
                if (q.tx_half != 3'h1) begin
                    d.tx_half = q.tx_half - 3'h1;
                end else begin
                    case (q.tx_st)
                        TX_START: begin
                            d.tx_st = TX_DATA;
                            d.tx_idx = 3'h0;
                            d.tx_half = `ULC_HALF_BIT;
                        end
                        TX_DATA: begin
                            if (q.tx_idx == last_idx) begin
                                if (q.lctl[`ULC_PAR_BIT]) begin
                                    d.tx_st = TX_PAR;
                                    d.tx_half = `ULC_HALF_BIT;
                                end else begin
                                    d.tx_st = TX_STOP;
                                    d.tx_half = stop_halves;
                                end
                            end else begin
                                d.tx_idx = q.tx_idx + 3'h1;
                                d.tx_half = `ULC_HALF_BIT;
                            end
                        end
                        TX_PAR: begin
                            d.tx_st = TX_STOP;
                            d.tx_half = stop_halves;
                        end
                        default: d.tx_st = TX_IDLE;
                    endcase
                end
            end
        end

        // ****************************************************************
        // Receiver
        // ****************************************************************
        if (q.rx_st == RX_IDLE) begin
            if (!rx_line) begin
                d.rx_st = RX_START;
                d.rx_cnt = 16'h0000;
                d.rx_half = 3'h1;
            end
        end else begin
            d.rx_cnt = rx_tick ? 16'h0000 : q.rx_cnt + 16'h0001;
            if (rx_tick) begin
                if (q.rx_half != 3'h1) begin
                    d.rx_half = q.rx_half - 3'h1;
                end else begin
                    d.rx_half = `ULC_HALF_BIT;
                    case (q.rx_st)
                        RX_START: begin
                            // A start bit gone high by mid-bit was a glitch
                            d.rx_st = rx_line ? RX_IDLE : RX_DATA;
                            d.rx_idx = 3'h0;
                            d.rx_sh = 8'h00;
                        end
                        RX_DATA: begin
                            d.rx_sh[q.rx_idx] = rx_line;
                            if (q.rx_idx == last_idx) begin
                                d.rx_st = q.lctl[`ULC_PAR_BIT] ? RX_PAR : RX_STOP;
                            end else begin
                                d.rx_idx = q.rx_idx + 3'h1;
                            end
                        end
                        RX_PAR: begin
                            d.rx_pbad = rx_line !=
                                par_f(q.rx_sh, q.lctl[1:0], q.lctl[`ULC_EPS_BIT]);
                            d.rx_st = RX_STOP;
                        end
                        RX_STOP: begin
                            // Later stop bits are never looked at
                            d.rx_st = RX_IDLE;
                            d.rx_data = q.rx_sh;
                            d.rx_rdy = 1'b1;
                            // Build on the cleared copy so a same-cycle status read loses
                            d.fe = d.fe | !rx_line;
                            d.pe = d.pe | (q.lctl[`ULC_PAR_BIT] & q.rx_pbad);
                            d.rx_pbad = 1'b0;
                        end
                        default: d.rx_st = RX_IDLE;
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            q <= '0;
            q.lctl <= `ULC_LCTL_RST;
            q.dll <= `ULC_DIV_RST;
            q.divisor_high <= `ULC_DIV_RST;
            q.ser <= 1'b1;
            q.txd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign RDATA_O = q.rdata;
    assign TXD_O = q.txd;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    sequence enter_stop_s;
        (q.tx_st != TX_STOP) ##1 (q.tx_st == TX_STOP);
    endsequence

    sequence leave_data_s;
        (q.tx_st == TX_DATA) ##1 (q.tx_st != TX_DATA);
    endsequence

    dlab_read_a: assert property (
        (RD_I && ADDR_I == `ULC_OFF_DATA && q.lctl[`ULC_DLAB_BIT])
        |=> RDATA_O == {24'h00_0000, $past(q.dll)})
        else $error("divisor low not returned under divisor select");
    dlab_write_a: assert property (
        (WR_I && ADDR_I == `ULC_OFF_DATA && q.lctl[`ULC_DLAB_BIT])
        |=> q.dll == $past(WDATA_I[7:0]) && q.tx_st == $past(q.tx_st))
        else $error("divisor low write leaked to transmitter");
    break_low_a: assert property (
        (q.lctl[`ULC_BRK_BIT] && !q.loop_en) [*2] |=> !TXD_O)
        else $error("break not driving line low");
    loop_high_a: assert property (
        q.loop_en |=> TXD_O)
        else $error("pin not high in loopback");
    parity_lock_a: assert property (
        (WR_I && ADDR_I == `ULC_OFF_LCTL && busy) |=> q.lctl[4:3] == $past(q.lctl[4:3]))
        else $error("parity bits changed while busy");
    parity_gate_a: assert property (
        (q.tx_st == TX_PAR || q.rx_st == RX_PAR) |-> q.lctl[`ULC_PAR_BIT])
        else $error("parity bit sent with parity off");
    parity_val_a: assert property (
        (q.tx_st == TX_PAR && !q.lctl[`ULC_BRK_BIT])
        |-> ^{ser, q.tx_sh & ~(8'hE0 << q.lctl[1:0])} == !q.lctl[`ULC_EPS_BIT])
        else $error("wrong parity sense");
    stop_len_a: assert property (
        enter_stop_s |-> q.tx_half == (!$past(q.lctl[`ULC_STOP_BIT]) ? 3'h2 :
                         ($past(q.lctl[1:0]) == 2'h0) ? 3'h3 : 3'h4))
        else $error("wrong stop length");
    char_len_a: assert property (
        leave_data_s |-> $past(q.tx_idx) == {1'b0, $past(q.lctl[1:0])} + 3'h4)
        else $error("wrong character length");
    first_stop_a: assert property (
        (q.rx_st == RX_STOP && rx_tick && q.rx_half == 3'h1)
        |=> q.rx_st == RX_IDLE && q.rx_rdy)
        else $error("receiver waited past first stop bit");

endmodule : ulc_line_ctrl

/* File: sim/ulc_remote_dev.sv */
// Remote serial device model: captures frames on the transmit pin, sends frames on receive
module ulc_remote_dev (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Frame capture and send, bit of two clocks
    // ****************************************************************
    // Timing assumes divisor 0 or 1; a larger divisor makes captures meaningless
    int frames = 0;
    logic [9:0] last = '1;
    initial rxd_o = 1'b1;
    initial begin
        forever begin
            @(negedge txd_i);
            @(posedge clk_i);
            for (int i = 0; i < 10; i++) begin
                repeat (2) @(posedge clk_i);
                #1 last[i] = txd_i;
            end
            frames++;
        end
    end
    task automatic send(input logic [9:0] bits, input int n);
        @(posedge clk_i) rxd_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            rxd_o <= bits[i];
            repeat (2) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask : send
endmodule : ulc_remote_dev

/* File: sim/ulc_line_ctrl_tb_top.sv */
// Self-checking bench of the line control block
`include "ulc_defines.svh"
module ulc_line_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] lctl; logic [7:0] d; logic [9:0] frame; logic [7:0] rx;} ulc_row_t;
    ulc_row_t rows [5] = '{'{8'h00, 8'h15, 10'h3F5, 8'h15}, '{8'h09, 8'h2C, 10'h3AC, 8'h2C},
        '{8'h1A, 8'h5B, 10'h3DB, 8'h5B}, '{8'h0B, 8'hA6, 10'h3A6, 8'hA6},
        '{8'h1B, 8'hC3, 10'h2C3, 8'hC3}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic re = 1'b0;
    logic rxd;
    logic txd;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] q;
    int fail_count = 0;
    int total_checks = 0;
    int n0;
    int n1;
    int f0;
    ulc_line_ctrl ulc_line_ctrl_i (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(we), .RD_I(re), .RXD_I(rxd), .RDATA_O(rdata), .TXD_O(txd));
    ulc_remote_dev ulc_remote_dev_i (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
    initial begin
        forever #20 clk = ~clk;
    end
    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
        @(posedge clk) we <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk) begin addr <= a; re <= 1'b1; end
        @(posedge clk) re <= 1'b0;
        @(negedge clk) d = rdata;
        @(negedge clk) chk(rdata, 32'h0000_0000);
    endtask : bus_rd
    // Back-to-back status reads give busy every cycle, so stop lengths resolve to one clock
    task automatic wait_idle(output int n);
        n = 0;
        @(posedge clk) begin addr <= `ULC_OFF_STAT; re <= 1'b1; end
        @(posedge clk);
        @(negedge clk);
        while (rdata[0] !== 1'b0 && n < 400) begin @(negedge clk); n++; end
        @(posedge clk) re <= 1'b0;
        chk(32'(n < 400), 32'h0000_0001);
    endtask : wait_idle
    task automatic wait_frame(input int f);
        for (int k = 0; k < 100 && ulc_remote_dev_i.frames == f; k++) @(posedge clk);
    endtask : wait_frame
    task automatic meas(input logic [7:0] l, output int n);
        bus_wr(`ULC_OFF_LCTL, {24'h0, l});
        bus_wr(`ULC_OFF_DATA, 32'h0000_0000);
        wait_idle(n);
    endtask : meas
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, txd}, 32'h0000_0001);
        bus_rd(`ULC_OFF_LCTL, q); chk(q, 32'h0000_0000);
        bus_rd(`ULC_OFF_MCTL, q); chk(q, 32'h0000_0000);
        bus_rd(32'h5002_0100, q); chk(q, 32'h0000_0000);
        bus_wr(`ULC_OFF_LCTL, 32'hFFFF_FF20);
        bus_rd(`ULC_OFF_LCTL, q); chk(q, 32'h0000_0000);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0083);
        bus_wr(`ULC_OFF_DATA, 32'h0000_0001);
        bus_wr(`ULC_OFF_DIVH, 32'h0000_005A);
        bus_rd(`ULC_OFF_DATA, q); chk(q, 32'h0000_0001);
        bus_rd(`ULC_OFF_DIVH, q); chk(q, 32'h0000_005A);
        bus_wr(`ULC_OFF_DIVH, 32'h0000_0000);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0003);
        bus_wr(`ULC_OFF_DIVH, 32'h0000_0033);
        bus_rd(`ULC_OFF_DIVH, q); chk(q, 32'h0000_0000);
        foreach (rows[i]) begin
            bus_wr(`ULC_OFF_LCTL, {24'h0, rows[i].lctl});
            f0 = ulc_remote_dev_i.frames;
            bus_wr(`ULC_OFF_DATA, {24'h0, rows[i].d});
            wait_idle(n0);
            wait_frame(f0);
            chk({22'h0, ulc_remote_dev_i.last}, {22'h0, rows[i].frame});
            ulc_remote_dev_i.send(rows[i].frame, 10);
            bus_rd(`ULC_OFF_DATA, q); chk(q, {24'h0, rows[i].rx});
            bus_rd(`ULC_OFF_STAT, q); chk(q & 32'h0000_000C, 32'h0000_0000);
        end
        ulc_remote_dev_i.send(10'h3C3, 10);
        bus_rd(`ULC_OFF_STAT, q); chk(q & 32'h0000_000C, 32'h0000_0008);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0003);
        ulc_remote_dev_i.send(10'h255, 10);
        bus_rd(`ULC_OFF_STAT, q); chk(q & 32'h0000_000C, 32'h0000_0004);
        bus_wr(`ULC_OFF_DATA, 32'h0000_0000);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_001F);
        bus_rd(`ULC_OFF_LCTL, q); chk(q, 32'h0000_0007);
        wait_idle(n0);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_001F);
        bus_rd(`ULC_OFF_LCTL, q); chk(q, 32'h0000_001F);
        meas(8'h00, n0);
        meas(8'h04, n1);
        chk(32'(n1 - n0), 32'h0000_0001);
        meas(8'h03, n0);
        meas(8'h07, n1);
        chk(32'(n1 - n0), 32'h0000_0002);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0040);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 24; i++) begin
            @(negedge clk) chk({31'h0, txd}, 32'h0000_0000);
        end
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        @(negedge clk) chk({31'h0, txd}, 32'h0000_0001);
        bus_wr(`ULC_OFF_MCTL, 32'h0000_0010);
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0003);
        bus_wr(`ULC_OFF_DATA, 32'h0000_00A5);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk) chk({31'h0, txd}, 32'h0000_0001);
        end
        bus_rd(`ULC_OFF_DATA, q); chk(q, 32'h0000_00A5);
        // Mid-run reset must bring line control and loopback settings back
        bus_wr(`ULC_OFF_LCTL, 32'h0000_0083);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, txd}, 32'h0000_0001);
        bus_rd(`ULC_OFF_LCTL, q); chk(q, 32'h0000_0000);
        bus_rd(`ULC_OFF_MCTL, q); chk(q, 32'h0000_0000);
        stop_test();
    end
endmodule : ulc_line_ctrl_tb_top
